// ### verilog/ref_input_freq_monitor.sv
// Frequency monitor for one reference input with hysteresis and validation timer
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
// Contract
// [RULE1] Hysteresis code 0..7 gives 0, 3.125, 6.25, 12.5, 25, 50, 75, 87.5% of limit.
// [RULE2] The selected hysteresis is applied to the fault decision. Here it sets only the clear level; the fault level stays the limit.
// [RULE3] Reference declared valid only after staying in tolerance for the full time.
// [RULE4] Validation time counts one millisecond per count of the 20-bit field.
// [RULE5] Software never programs validation time as all zeros or all ones.
// [RULE6] The 24-bit ppb offset limit is the largest error tolerated before fault.
// [RULE7] Fault above limit; clear below limit minus hysteresis; restart timing on fault.
module ref_input_freq_monitor
    import ref_mon_pkg::*;
#(
    parameter int MS_CYCLES_P = MS_CYCLES
) (
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire err_sample_t       err_in,
    output logic                   ref_fault,
    output logic                   ref_valid,
    output logic                   irq
);
    // ************************************************************
    // Registers
    // ************************************************************
    logic [LIMIT_W-1:0] limit_reg;
    logic [HYST_W-1:0]  hyst_reg;
    logic [VTIME_W-1:0] vtime_reg;
    logic [15:0]        jitter_reg;
    logic [1:0]         irq_stat_reg;
    logic [1:0]         irq_mask_reg;
    logic [1:0]         irq_set;
    mon_state_t         state_reg;
    logic [31:0]        ms_cnt_reg;
    logic [VTIME_W-1:0] vcnt_reg;
    logic               ms_tick;
    logic [LIMIT_W-1:0] hyst_amt;
    logic [LIMIT_W-1:0] clear_level;
    logic               over_limit;
    logic               below_clear;
    logic               access;
    logic [15:0]        idx;
    logic               mapped;
    logic [31:0]        rdata;

    assign access = psel && penable;
    assign idx    = 16'(paddr[ADDR_W-1:2]);

    // ************************************************************
    // Hysteresis decode
    // ************************************************************
    always_comb begin
        unique case (hyst_reg) // [RULE1]
            3'h0: hyst_amt = '0;
            3'h1: hyst_amt = limit_reg >> 5;
            3'h2: hyst_amt = limit_reg >> 4;
            3'h3: hyst_amt = limit_reg >> 3;
            3'h4: hyst_amt = limit_reg >> 2;
            3'h5: hyst_amt = limit_reg >> 1;
            3'h6: hyst_amt = (limit_reg >> 1) + (limit_reg >> 2);
            3'h7: hyst_amt = limit_reg - (limit_reg >> 3);
        endcase
    end

    assign clear_level = limit_reg - hyst_amt;                      // [RULE2]
    assign over_limit  = err_in.valid && (err_in.error_ppb > limit_reg); // [RULE6]
    assign below_clear = err_in.valid && (err_in.error_ppb < clear_level); // [RULE7]

    // ************************************************************
    // Millisecond divider
    // ************************************************************
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ms_cnt_reg <= '0;
        end else if (state_reg != ST_VALIDATE || ms_tick) begin
            ms_cnt_reg <= '0;
        end else begin
            ms_cnt_reg <= ms_cnt_reg + 32'h1;
        end
    end
    assign ms_tick = (ms_cnt_reg == 32'(MS_CYCLES_P - 1));         // [RULE4]

    // ************************************************************
    // Monitor state machine
    // ************************************************************
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_FAULT;
            vcnt_reg  <= '0;
        end else begin
            unique case (state_reg)
                ST_FAULT: begin
                    vcnt_reg <= '0;
                    if (below_clear) begin
                        state_reg <= ST_VALIDATE;                   // [RULE7]
                    end
                end
                ST_VALIDATE: begin
                    if (over_limit) begin
                        state_reg <= ST_FAULT;                      // [RULE7]
                    end else if (ms_tick) begin
                        if (vcnt_reg + 20'h1 >= vtime_reg) begin
                            state_reg <= ST_VALID;                  // [RULE3]
                        end
                        vcnt_reg <= vcnt_reg + 20'h1;               // [RULE4]
                    end
                end
                ST_VALID: begin
                    vcnt_reg <= '0;
                    if (over_limit) begin
                        state_reg <= ST_FAULT;                      // [RULE6]
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ref_fault <= 1'b1;
            ref_valid <= 1'b0;
        end else begin
            ref_fault <= (state_reg == ST_FAULT);
            ref_valid <= (state_reg == ST_VALID);
        end
    end

    // ************************************************************
    // Interrupts
    // ************************************************************
    assign irq_set[IRQ_FAULT] = (state_reg != ST_FAULT) && over_limit;
    assign irq_set[IRQ_VALID] = (state_reg == ST_VALIDATE) && !over_limit && ms_tick
                                && (vcnt_reg + 20'h1 >= vtime_reg);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_stat_reg <= '0;
        end else if (access && pwrite && idx == IDX_IRQ_STATUS) begin
            irq_stat_reg <= (irq_stat_reg & ~pwdata[1:0]) | irq_set;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_set;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |((irq_stat_reg | irq_set) & irq_mask_reg);
        end
    end

    // ************************************************************
    // APB register file
    // ************************************************************
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            limit_reg    <= {RST_OFFSET_LIMIT_HIGH, RST_OFFSET_LIMIT_MID, RST_OFFSET_LIMIT_LOW};
            hyst_reg     <= RST_HYST_CODE;
            vtime_reg    <= {RST_VALID_TIME_HIGH, RST_VALID_TIME_MID, RST_VALID_TIME_LOW};
            jitter_reg   <= '0;
            irq_mask_reg <= RST_IRQ_MASK;
        end else if (access && pwrite) begin
            unique case (idx)
                IDX_OFFSET_LIMIT_LOW:  limit_reg[7:0]    <= pwdata[7:0];
                IDX_OFFSET_LIMIT_MID:  limit_reg[15:8]   <= pwdata[7:0];
                IDX_OFFSET_LIMIT_HIGH: limit_reg[23:16]  <= pwdata[7:0];
                IDX_HYST_SELECT:       hyst_reg          <= pwdata[2:0];
                IDX_VALID_TIME_LOW:    vtime_reg[7:0]    <= pwdata[7:0];
                IDX_VALID_TIME_MID:    vtime_reg[15:8]   <= pwdata[7:0];
                IDX_VALID_TIME_HIGH:   vtime_reg[19:16]  <= pwdata[3:0];
                IDX_JITTER_LOW:        jitter_reg[7:0]   <= pwdata[7:0];
                IDX_JITTER_HIGH:       jitter_reg[15:8]  <= pwdata[7:0];
                IDX_IRQ_MASK:          irq_mask_reg      <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        rdata  = '0;
        mapped = 1'b1;
        unique case (idx)
            IDX_OFFSET_LIMIT_LOW:  rdata[7:0] = limit_reg[7:0];
            IDX_OFFSET_LIMIT_MID:  rdata[7:0] = limit_reg[15:8];
            IDX_OFFSET_LIMIT_HIGH: rdata[7:0] = limit_reg[23:16];
            IDX_HYST_SELECT:       rdata[2:0] = hyst_reg;
            IDX_VALID_TIME_LOW:    rdata[7:0] = vtime_reg[7:0];
            IDX_VALID_TIME_MID:    rdata[7:0] = vtime_reg[15:8];
            IDX_VALID_TIME_HIGH:   rdata[3:0] = vtime_reg[19:16];
            IDX_JITTER_LOW:        rdata[7:0] = jitter_reg[7:0];
            IDX_JITTER_HIGH:       rdata[7:0] = jitter_reg[15:8];
            IDX_STATUS:            rdata[2:0] = state_reg;
            IDX_IRQ_STATUS:        rdata[1:0] = irq_stat_reg;
            IDX_IRQ_MASK:          rdata[1:0] = irq_mask_reg;
            default:               mapped     = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= (psel && !penable && !pwrite) ? rdata : 32'h0;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    chk_fault_on_excess: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE6]
        (state_reg == ST_VALID && over_limit) |=> state_reg == ST_FAULT)
        else $error("Excess error did not fault the reference");
    chk_hyst_clear_gate: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE7]
        (state_reg == ST_FAULT && !below_clear) |=> state_reg == ST_FAULT)
        else $error("Fault cleared without falling below hysteresis level");
    chk_hyst_none_level: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE1]
        (hyst_reg == 3'h0) |-> clear_level == limit_reg)
        else $error("Zero hysteresis code changed the clear level");
    chk_hyst_half_level: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE2]
        (hyst_reg == 3'h5) |-> clear_level == limit_reg - (limit_reg >> 1))
        else $error("Half hysteresis clear level wrong");
    chk_valid_needs_time: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE3]
        $rose(state_reg == ST_VALID) |-> $past(ms_tick) && $past(vcnt_reg) + 20'h1 >= vtime_reg)
        else $error("Reference declared valid before validation time");
    chk_ms_tick_period: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE4]
        (state_reg == ST_VALIDATE && !ms_tick) |=> vcnt_reg == $past(vcnt_reg))
        else $error("Validation count moved between millisecond ticks");
    chk_restart_on_fault: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE7]
        (state_reg == ST_FAULT) |=> vcnt_reg == '0)
        else $error("Validation count not restarted on fault");
    chk_irq_level: assert property (@(posedge sys_clk) disable iff (!nrst)
        (|(irq_stat_reg & irq_mask_reg)) |=> irq)
        else $error("Unmasked status did not raise interrupt");
    chk_fault_from_validate: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE7]
        (state_reg == ST_VALIDATE && over_limit) |=> state_reg == ST_FAULT)
        else $error("Excess error during validation did not fault the reference");
    chk_valid_holds: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE6]
        (state_reg == ST_VALID && !over_limit) |=> state_reg == ST_VALID)
        else $error("Valid reference faulted without excess error");
    chk_clear_below_level: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE7]
        (state_reg == ST_FAULT && below_clear) |=> state_reg == ST_VALIDATE)
        else $error("Error below clear level did not start validation");
    chk_hyst_full_level: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE1]
        (hyst_reg == 3'h7) |-> clear_level == (limit_reg >> 3))
        else $error("Largest hysteresis clear level wrong");
    chk_hyst_quarter_level: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE1]
        (hyst_reg == 3'h4) |-> clear_level == limit_reg - (limit_reg >> 2))
        else $error("Quarter hysteresis clear level wrong");
    chk_fault_output: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE6]
        (state_reg == ST_FAULT) |=> ref_fault)
        else $error("Fault state not shown on fault output");
    chk_valid_excludes_fault: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE3]
        ref_valid |-> !ref_fault)
        else $error("Reference shown valid and faulted together");
    chk_vcnt_step: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE4]
        (state_reg == ST_VALIDATE && ms_tick && !over_limit) |=> vcnt_reg == $past(vcnt_reg) + 20'h1)
        else $error("Validation count did not advance on millisecond tick");
    chk_ms_count_range: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE4]
        ms_cnt_reg < 32'(MS_CYCLES_P))
        else $error("Millisecond divider ran past its period");
    chk_restart_timer: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE7]
        $rose(state_reg == ST_VALIDATE) |-> ms_cnt_reg == 32'h0 && vcnt_reg == 20'h0)
        else $error("Validation did not start from a cleared timer");
    chk_irq_set_wins: assert property (@(posedge sys_clk) disable iff (!nrst)
        (irq_set != 2'h0) |=> (irq_stat_reg & $past(irq_set)) == $past(irq_set))
        else $error("Interrupt event lost");
    chk_irq_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
        !(|((irq_stat_reg | irq_set) & irq_mask_reg)) |=> !irq)
        else $error("Interrupt high without unmasked status");
    chk_pready_pulse: assert property (@(posedge sys_clk) disable iff (!nrst)
        pready |=> !pready)
        else $error("Ready held longer than one cycle");
    chk_pslverr_pair: assert property (@(posedge sys_clk) disable iff (!nrst)
        pslverr |-> pready)
        else $error("Slave error without ready");

    // ************************************************************
    // Cover properties
    // ************************************************************
    cov_becomes_valid: cover property (@(posedge sys_clk) disable iff (!nrst)
        $rose(ref_valid));
    cov_valid_faults: cover property (@(posedge sys_clk) disable iff (!nrst)
        ref_valid ##1 ref_fault);
    cov_validate_abort: cover property (@(posedge sys_clk) disable iff (!nrst)
        state_reg == ST_VALIDATE ##1 state_reg == ST_FAULT);
    cov_deep_hyst_clear: cover property (@(posedge sys_clk) disable iff (!nrst)
        hyst_reg == 3'h7 && state_reg == ST_FAULT ##1 state_reg == ST_VALIDATE);
    cov_irq_raised: cover property (@(posedge sys_clk) disable iff (!nrst)
        $rose(irq));
endmodule

// ### verilog/ref_mon_pkg.sv
// Package: register map, field layouts, reset values and timing for the reference monitor
package ref_mon_pkg;
    // ************************************************************
    // Register indices (printed offsets) and address width
    // ************************************************************
    localparam logic [15:0] IDX_OFFSET_LIMIT_LOW  = 16'h042c;
    localparam logic [15:0] IDX_OFFSET_LIMIT_MID  = 16'h042d;
    localparam logic [15:0] IDX_OFFSET_LIMIT_HIGH = 16'h042e;
    localparam logic [15:0] IDX_HYST_SELECT       = 16'h042f;
    localparam logic [15:0] IDX_VALID_TIME_LOW    = 16'h0430;
    localparam logic [15:0] IDX_VALID_TIME_MID    = 16'h0431;
    localparam logic [15:0] IDX_VALID_TIME_HIGH   = 16'h0432;
    localparam logic [15:0] IDX_JITTER_LOW        = 16'h0433;
    localparam logic [15:0] IDX_JITTER_HIGH       = 16'h0434;
    localparam logic [15:0] IDX_STATUS            = 16'h0435;
    localparam logic [15:0] IDX_IRQ_STATUS        = 16'h0436;
    localparam logic [15:0] IDX_IRQ_MASK          = 16'h0437;
    localparam int          ADDR_W                = 18;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_OFFSET_LIMIT_LOW  = 8'ha0;
    localparam logic [7:0] RST_OFFSET_LIMIT_MID  = 8'h86;
    localparam logic [7:0] RST_OFFSET_LIMIT_HIGH = 8'h01;
    localparam logic [2:0] RST_HYST_CODE         = 3'h3;
    localparam logic [7:0] RST_VALID_TIME_LOW    = 8'h0a;
    localparam logic [7:0] RST_VALID_TIME_MID    = 8'h00;
    localparam logic [3:0] RST_VALID_TIME_HIGH   = 4'h0;
    localparam logic [1:0] RST_IRQ_MASK          = 2'h0;

    // ************************************************************
    // Field layout and widths
    // ************************************************************
    localparam int HYST_W    = 3;
    localparam int LIMIT_W   = 24;
    localparam int VTIME_W   = 20;
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_VALID = 1;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int SYS_CLK_HZ  = 20000000;
    localparam int MS_PERIOD_US = 1000;
    localparam int MS_CYCLES   = SYS_CLK_HZ / 1000000 * MS_PERIOD_US;

    typedef enum logic [2:0] {
        ST_FAULT    = 3'b001,
        ST_VALIDATE = 3'b010,
        ST_VALID    = 3'b100
    } mon_state_t;

    typedef struct packed {
        logic        valid;
        logic [23:0] error_ppb;
    } err_sample_t;
endpackage

// ### tb/ref_err_source.sv
// Partner model: measured frequency error of the monitored reference input
`timescale 1ns/100ps
module ref_err_source
    import ref_mon_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        meas_en,
    input  wire logic [23:0] meas_ppb,
    output err_sample_t      err_in
);
    logic [23:0] last_reg = 24'h000000;

    // ************************************************************
    // Sample bus: idle samples show the inverse of the last value
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (meas_en) begin
            last_reg <= meas_ppb;
        end
    end
    assign err_in = {meas_en, (meas_en ? meas_ppb : ~last_reg)};
endmodule

// ### tb/ref_input_freq_monitor_bench.sv
// Testbench for the reference input frequency monitor
`timescale 1ns/100ps
module ref_input_freq_monitor_bench
    import ref_mon_pkg::*;
;
    localparam int          MSP = 4;
    localparam int          HK [8] = '{0, 1, 2, 4, 8, 16, 24, 28};
    localparam logic [31:0] RST_TAB [12] = '{32'ha0, 32'h86, 32'h01, 32'h03, 32'h0a, 32'h00,
                                             32'h00, 32'h00, 32'h00, 32'h01, 32'h00, 32'h00};
    logic              sys_clk  = 1'b0;
    logic              nrst     = 1'b0;
    logic [ADDR_W-1:0] paddr    = '0;
    logic              psel     = 1'b0;
    logic              penable  = 1'b0;
    logic              pwrite   = 1'b0;
    logic [31:0]       pwdata   = 32'h0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    err_sample_t       err_in;
    logic              ref_fault;
    logic              ref_valid;
    logic              irq;
    logic              meas_en  = 1'b0;
    logic [23:0]       meas_ppb = 24'h000000;
    logic [31:0]       rdat;
    logic              serr;
    int                error_cnt = 0;
    int                n_tests   = 0;
    int                cyc       = 0;
    int                n;
    int                h;

    always #25 sys_clk = ~sys_clk;

    ref_input_freq_monitor #(.MS_CYCLES_P(MSP)) ref_input_freq_monitor_i (
        .sys_clk(sys_clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .err_in(err_in), .ref_fault(ref_fault), .ref_valid(ref_valid),
        .irq(irq));
    ref_err_source ref_err_source_i (
        .sys_clk(sys_clk), .meas_en(meas_en), .meas_ppb(meas_ppb), .err_in(err_in));

    // ************************************************************
    // Tasks
    // ************************************************************
    task conclude;
        $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task apb(input logic [15:0] idx, input logic w, input logic [31:0] d);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= {idx, 2'b00};
        pwrite  <= w;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rdat = prdata;
        serr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [15:0] idx, input logic [31:0] d);
        apb(idx, 1'b1, d);
    endtask

    task rd(input logic [15:0] idx, input logic [31:0] exp);
        apb(idx, 1'b0, 32'h0);
        chk(rdat, exp);
    endtask

    task set_err(input logic [23:0] e, input int hold);
        @(posedge sys_clk);
        meas_en  <= 1'b1;
        meas_ppb <= e;
        repeat (hold) @(posedge sys_clk);
    endtask

    task wait_valid;
        n = 0;
        while (ref_valid !== 1'b1 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            rd(IDX_OFFSET_LIMIT_LOW + 16'(i), RST_TAB[i]);
            chk(32'(serr), 32'h0);
        end
        rd(16'h0438, 32'h0);
        chk(32'(serr), 32'h1);
        wr(IDX_HYST_SELECT, 32'hff);
        rd(IDX_HYST_SELECT, 32'h07);
        wr(IDX_VALID_TIME_HIGH, 32'hff);
        rd(IDX_VALID_TIME_HIGH, 32'h0f);
        wr(IDX_VALID_TIME_HIGH, 32'h00);
        wr(IDX_OFFSET_LIMIT_LOW, 32'h00);
        wr(IDX_OFFSET_LIMIT_MID, 32'h04);
        wr(IDX_OFFSET_LIMIT_HIGH, 32'h00);
        wr(IDX_VALID_TIME_LOW, 32'h03);
        $display("Register map test done");
        for (int c = 0; c < 8; c++) begin
            wr(IDX_HYST_SELECT, 32'(c));
            h = 1024 * HK[c] / 32;
            set_err(24'h000401, 6);
            chk(32'(ref_fault), 32'h1);
            set_err(24'(1024 - h), 6);
            chk(32'(ref_fault), 32'h1);
            set_err(24'(1023 - h), 6);
            chk(32'(ref_fault), 32'h0);
            rd(IDX_STATUS, 32'h2);
            set_err(24'h000400, 6);
            chk(32'(ref_fault), 32'h0);
        end
        $display("Hysteresis test done");
        set_err(24'h0007d0, 6);
        set_err(24'h000064, 0);
        wait_valid();
        chk(32'(n >= 3 * MSP && n <= 3 * MSP + 6), 32'h1);
        set_err(24'h0007d0, 6);
        set_err(24'h000064, 9);
        chk(32'(ref_valid), 32'h0);
        set_err(24'h0007d0, 1);
        set_err(24'h000064, 0);
        wait_valid();
        chk(32'(n >= 3 * MSP && n <= 3 * MSP + 6), 32'h1);
        @(posedge sys_clk);
        meas_en <= 1'b0;
        repeat (10) @(posedge sys_clk);
        chk(32'(ref_valid), 32'h1);
        rd(IDX_STATUS, 32'h4);
        $display("Validation test done");
        rd(IDX_IRQ_STATUS, 32'h3);
        chk(32'(irq), 32'h0);
        wr(IDX_IRQ_MASK, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk(32'(irq), 32'h1);
        wr(IDX_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk(32'(irq), 32'h0);
        rd(IDX_IRQ_STATUS, 32'h2);
        wr(IDX_IRQ_MASK, 32'h2);
        repeat (2) @(posedge sys_clk);
        chk(32'(irq), 32'h1);
        wr(IDX_IRQ_STATUS, 32'h2);
        repeat (2) @(posedge sys_clk);
        chk(32'(irq), 32'h0);
        $display("Interrupt test done");
        conclude();
    end
endmodule
